// ==== verilog/dic_input_cond.sv ====
// Our own choices: the address map and strobed register access.
`default_nettype none
// Operation
// - sample inputs each millisecond, ignore shorter pulses
// - diff mode gives three pairs, from inputs 1..6
// - threshold mask bit selects 5 V or 24 V
// - gate bits enable limit, home, interlock functions
// - gate touches special bits only, not levels
// - polarity bit makes normally-closed input logic
// - override select replaces sampled level
// - override level supplies forced input value
// - raw entry shows sampled levels unmodified
// - input 1 feeds bit 0 and bit 16
// - writing 1 to route entry enables routing
// - routing bypasses gate, polarity, override entries; gate bit 3 still enables interlock
// - routing enable preloads map preserving behaviour
// - map entry n drives summary bit n
// - codes 00..10 give zero or input
// - codes 80..90 give one or inverted input
// - interlock bit low forces error state
// - special bits 0..3, levels 16..31
module dic_input_cond #(
  parameter int MS_CYCLES = dic_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dic_pkg::N_PINS-1:0] pin_in,
  input wire dic_pkg::dic_bus_type bus_req,
  output logic [31:0] rdata,
  output logic [dic_pkg::N_PINS-1:0] thresh_24v,
  output logic diff_mode,
  output logic [31:0] summary,
  output logic motion_permit,
  output logic ilock_error,
  output logic ilock_event
);
  import dic_pkg::*;

  localparam int CW = $clog2(MS_CYCLES + 1);

  // ==========================================================
  // hazards and limits
  // - an input needs up to two millisecond ticks plus the pin chain before it
  //   shows in the raw register, and one more cycle before the summary word;
  //   a fast edge on a limit switch is therefore seen late, never early
  // - the threshold mask only leaves the block as a pin word; the analog
  //   front end that acts on it sits outside this logic
  // - the interlock output is a level; the fault reaction itself is left to
  //   whoever watches the error and its one-cycle entry pulse
  // - toggling routing on and off rewrites the source map each time it turns
  //   on, so software edits to the table are lost by a re-enable

  // ==========================================================
  // source decode for routing
  // the low seven bits pick a physical input, bit 7 inverts the result;
  // a code that names no input yields the constant, so an unused code is
  // harmless: zero below the inverted range, one inside it
  function automatic logic src_bit(input logic [7:0] code,
                                   input logic [N_PINS-1:0] raw);
    logic [6:0] idx;
    logic v;
    idx = code[6:0];
    v = 1'b0;
    for (int k = 1; k <= N_PINS; k++) begin
      if (idx == 7'(k)) begin
        v = raw[k-1];
      end
    end
    return v ^ code[SRC_INV_BIT];
  endfunction : src_bit

  // ==========================================================
  // pin synchroniser and glitch filter
  // each pin runs its own three-flop chain; the filtered level only follows
  // once flops two and three agree, so a metastable first flop never leaks
  wire logic [N_PINS-1:0] filt_lvl;

  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic s1_r, s2_r, s3_r, hold_r;
    logic s1_nxt, s2_nxt, s3_nxt, hold_nxt;

    always_comb begin
      s1_nxt = pin_in[i];
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      // keep the old level while the two late flops disagree
      hold_nxt = (s2_r == s3_r) ? s3_r : hold_r;
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
        s3_r <= s3_nxt;
        hold_r <= hold_nxt;
      end
    end

    assign filt_lvl[i] = hold_r;
  end : g_pin

  // ==========================================================
  // millisecond sampler
  // a free-running counter marks the tick; the pair conversion sits before
  // the sampler so both modes share the same pulse rejection
  // trade-off: two ticks of agreement cost up to two milliseconds of delay,
  // but a single tick could still latch a short spike that hits the edge
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [N_PINS-1:0] cand_r, cand_nxt, raw_r, raw_nxt, conv;
  logic tick;
  logic diff_r;

  always_comb begin
    conv = filt_lvl;
    if (diff_r) begin
      conv = '0;
      for (int p = 0; p < N_PAIRS; p++) begin
        // pair p: pin 2p is the minus leg, pin 2p+1 the plus leg
        conv[p] = filt_lvl[2*p+1] & ~filt_lvl[2*p];
      end
    end
  end

  always_comb begin
    tick = (cnt_r == CW'(MS_CYCLES - 1));
    cnt_nxt = tick ? '0 : cnt_r + 1'b1;
    cand_nxt = cand_r;
    raw_nxt = raw_r;
    if (tick) begin
      cand_nxt = conv;
      // a level must be seen on two ticks, so shorter pulses vanish
      raw_nxt = (conv & ~(conv ^ cand_r)) | (raw_r & (conv ^ cand_r));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      cand_r <= '0;
      raw_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      cand_r <= cand_nxt;
      raw_r <= raw_nxt;
    end
  end

  // ==========================================================
  // configuration registers
  // word map, byte addressed, one word per entry:
  //   gate mask, polarity mask, override select, override level,
  //   raw levels (read only), threshold mask, pair mode, routing switch,
  //   summary word (read only), then the source map from its own base
  // writes to read-only or unknown addresses are dropped without a trace,
  // and unknown reads answer zero, so a stray access cannot wedge the bus
  // map entries keep eight bits; the upper bits of a write are discarded
  logic [31:0] gate_r, pol_r, osel_r, olvl_r, thr_r;
  logic [31:0] gate_nxt, pol_nxt, osel_nxt, olvl_nxt, thr_nxt;
  logic diff_nxt, route_r, route_nxt;
  logic [7:0] map_r [N_MAP];
  logic [7:0] map_nxt [N_MAP];
  logic [7:0] pre_code [N_MAP];
  logic [31:0] rdata_r, rdata_nxt;
  logic map_hit;
  logic [4:0] map_idx;
  logic [31:0] sum_r, sum_nxt;

  always_comb begin
    // codes that reproduce the normal-mode result of each bit
    // a forced input becomes a constant code, since routing has no override;
    // an ungated special bit becomes the zero code
    for (int n = 0; n < N_MAP; n++) begin
      pre_code[n] = SRC_ZERO;
    end
    for (int i = 0; i < N_PINS; i++) begin
      pre_code[LEVEL_LSB+i] = osel_r[i] ? (olvl_r[i] ^ pol_r[i] ? SRC_ONE : SRC_ZERO)
                                         : {pol_r[i], 7'(i + 1)};
    end
    for (int s = 0; s < N_SPECIAL; s++) begin
      pre_code[s] = gate_r[s] ? pre_code[LEVEL_LSB+s] : SRC_ZERO;
    end
  end

  always_comb begin
    map_hit = (bus_req.addr >= A_MAP_BASE) && (bus_req.addr <= A_MAP_LAST)
              && (bus_req.addr[1:0] == 2'b00);
    map_idx = 5'((bus_req.addr - A_MAP_BASE) >> 2);
    gate_nxt = gate_r;
    pol_nxt = pol_r;
    osel_nxt = osel_r;
    olvl_nxt = olvl_r;
    thr_nxt = thr_r;
    diff_nxt = diff_r;
    route_nxt = route_r;
    for (int n = 0; n < N_MAP; n++) begin
      map_nxt[n] = map_r[n];
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        A_GATE: gate_nxt = bus_req.wdata;
        A_POL: pol_nxt = bus_req.wdata;
        A_OVR_SEL: osel_nxt = bus_req.wdata;
        A_OVR_LVL: olvl_nxt = bus_req.wdata;
        A_THRESH: thr_nxt = bus_req.wdata;
        A_DIFF: diff_nxt = bus_req.wdata[0];
        A_ROUTE: begin
          route_nxt = bus_req.wdata[0];
          if (bus_req.wdata[0] && !route_r) begin
            for (int n = 0; n < N_MAP; n++) begin
              map_nxt[n] = pre_code[n];
            end
          end
        end
        default: begin
          if (map_hit) begin
            map_nxt[map_idx] = bus_req.wdata[7:0];
          end
        end
      endcase
    end
  end

  // read side: answer one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = RST_WORD;
    if (bus_req.rd) begin
      case (bus_req.addr)
        A_GATE: rdata_nxt = gate_r;
        A_POL: rdata_nxt = pol_r;
        A_OVR_SEL: rdata_nxt = osel_r;
        A_OVR_LVL: rdata_nxt = olvl_r;
        A_RAW: rdata_nxt = 32'(raw_r);
        A_THRESH: rdata_nxt = thr_r;
        A_DIFF: rdata_nxt = 32'(diff_r);
        A_ROUTE: rdata_nxt = 32'(route_r);
        A_SUMMARY: rdata_nxt = sum_r;
        default: begin
          if (map_hit) begin
            rdata_nxt = 32'(map_r[map_idx]);
          end
        end
      endcase
    end
  end

  // configuration state registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_r <= RST_WORD;
      pol_r <= RST_WORD;
      osel_r <= RST_WORD;
      olvl_r <= RST_WORD;
      thr_r <= RST_WORD;
      diff_r <= 1'b0;
      route_r <= 1'b0;
      rdata_r <= RST_WORD;
      for (int n = 0; n < N_MAP; n++) begin
        map_r[n] <= SRC_ZERO;
      end
    end else begin
      gate_r <= gate_nxt;
      pol_r <= pol_nxt;
      osel_r <= osel_nxt;
      olvl_r <= olvl_nxt;
      thr_r <= thr_nxt;
      diff_r <= diff_nxt;
      route_r <= route_nxt;
      rdata_r <= rdata_nxt;
      for (int n = 0; n < N_MAP; n++) begin
        map_r[n] <= map_nxt[n];
      end
    end
  end

  // ==========================================================
  // summary word and interlock
  wire logic [N_PINS-1:0] lvl;
  wire logic [N_MAP-1:0] routed;
  logic ilock_en, err_r, err_nxt, evt_r, evt_nxt, permit_r, permit_nxt;
  logic [N_PINS-1:0] thr_out_r;

  // per-input level path; the raw value stays untouched for its own register
  for (genvar i = 0; i < N_PINS; i++) begin : g_lvl
    wire logic forced;
    assign forced = osel_r[i] ? olvl_r[i] : raw_r[i];
    assign lvl[i] = forced ^ pol_r[i];
  end : g_lvl

  // routing reads the raw levels directly, so override and polarity drop out
  for (genvar n = 0; n < N_MAP; n++) begin : g_route
    assign routed[n] = src_bit(map_r[n], raw_r);
  end : g_route

  // layout: special results in the low half, levels in the high half;
  // outside routing, bits between the four special bits and the levels read as zero
  always_comb begin
    sum_nxt = RST_WORD;
    sum_nxt[LEVEL_LSB +: N_PINS] = lvl;
    sum_nxt[N_SPECIAL-1:0] = lvl[N_SPECIAL-1:0] & gate_r[N_SPECIAL-1:0];
    if (route_r) begin
      // gate, polarity and override are ignored while routing
      sum_nxt = routed;
    end
  end

  always_comb begin
    // the enable stays with the gate bit even in routing mode
    // the error is a level, not a latch: a restored source clears it, and
    // the entry pulse is what a fault reaction should hang on
    // it follows the registered summary, so it trails the word by one cycle
    ilock_en = gate_r[ILOCK_BIT];
    permit_nxt = !ilock_en || sum_r[ILOCK_BIT];
    err_nxt = ilock_en && !sum_r[ILOCK_BIT];
    evt_nxt = err_nxt && !err_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sum_r <= RST_WORD;
      permit_r <= 1'b1;
      err_r <= 1'b0;
      evt_r <= 1'b0;
      thr_out_r <= '0;
    end else begin
      sum_r <= sum_nxt;
      permit_r <= permit_nxt;
      err_r <= err_nxt;
      evt_r <= evt_nxt;
      thr_out_r <= thr_nxt[N_PINS-1:0];
    end
  end

  // ==========================================================
  // outputs, each straight from its register
  // the threshold pins move in the same cycle as the mask register
  assign rdata = rdata_r;
  assign summary = sum_r;
  assign motion_permit = permit_r;
  assign ilock_error = err_r;
  assign ilock_event = evt_r;
  assign thresh_24v = thr_out_r;
  assign diff_mode = diff_r;
endmodule : dic_input_cond
`default_nettype wire

// ==== verilog/dic_pkg.sv ====
`default_nettype none
package dic_pkg;
  // ==========================================================
  // sizes
  localparam int N_PINS = 16;
  localparam int N_PAIRS = 3;
  localparam int N_SPECIAL = 4;
  localparam int N_MAP = 32;
  localparam int LEVEL_LSB = 16;
  localparam int ILOCK_BIT = 3;
  // ==========================================================
  // timing
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int CLK_MHZ = 200;
  localparam int MS_CYCLES = SAMPLE_PERIOD_US * CLK_MHZ;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] A_GATE = 8'h00;
  localparam logic [7:0] A_POL = 8'h04;
  localparam logic [7:0] A_OVR_SEL = 8'h08;
  localparam logic [7:0] A_OVR_LVL = 8'h0C;
  localparam logic [7:0] A_RAW = 8'h10;
  localparam logic [7:0] A_THRESH = 8'h14;
  localparam logic [7:0] A_DIFF = 8'h18;
  localparam logic [7:0] A_ROUTE = 8'h1C;
  localparam logic [7:0] A_SUMMARY = 8'h20;
  localparam logic [7:0] A_MAP_BASE = 8'h40;
  localparam logic [7:0] A_MAP_LAST = 8'hBC;
  // ==========================================================
  // reset values and source codes
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] SRC_ZERO = 8'h00;
  localparam logic [7:0] SRC_ONE = 8'h80;
  localparam int SRC_INV_BIT = 7;
  // ==========================================================
  // bus request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dic_bus_type;
endpackage : dic_pkg
`default_nettype wire

// ==== bench/dic_switches.sv ====
`default_nettype none
module dic_switches (
  input wire logic clk,
  input wire logic [15:0] want,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // contacts change just after an edge; bounce is made by the bench
  always_ff @(posedge clk) begin
    pin_in <= want;
  end
endmodule : dic_switches
`default_nettype wire

// ==== bench/dic_input_cond_props.sv ====
`default_nettype none
module dic_input_cond_props #(
  parameter int MS_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] pin_in,
  input wire dic_pkg::dic_bus_type bus_req,
  input wire logic [31:0] rdata,
  input wire logic [15:0] thresh_24v,
  input wire logic diff_mode,
  input wire logic [31:0] summary,
  input wire logic motion_permit,
  input wire logic ilock_error,
  input wire logic ilock_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;
  // ====
  // relations
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle; !bus_req.rd |=> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_thr; bus_req.wr && bus_req.addr == A_THRESH |=>
    thresh_24v == $past(bus_req.wdata[15:0]); endproperty
  a_thr: assert property (p_thr) else $error("threshold copy");
  property p_thr_rd; bus_req.rd && bus_req.addr == A_THRESH |=>
    rdata[15:0] == $past(thresh_24v); endproperty
  a_thr_rd: assert property (p_thr_rd) else $error("threshold read");
  property p_dif; bus_req.wr && bus_req.addr == A_DIFF |=>
    diff_mode == $past(bus_req.wdata[0]); endproperty
  a_dif: assert property (p_dif) else $error("diff mode");
  property p_sum; bus_req.rd && bus_req.addr == A_SUMMARY |=>
    rdata == $past(summary); endproperty
  a_sum: assert property (p_sum) else $error("summary read");
  property p_perm; motion_permit != ilock_error; endproperty
  a_perm: assert property (p_perm) else $error("permit vs error");
  property p_rise; $rose(ilock_error) |-> !$past(summary[3]); endproperty
  a_rise: assert property (p_rise) else $error("error cause");
  property p_evt; ilock_event |=> !ilock_event; endproperty
  a_evt: assert property (p_evt) else $error("event width");
  c_evt: cover property (ilock_event);
  c_dif: cover property (diff_mode);
  c_sum: cover property (bus_req.rd && bus_req.addr == A_SUMMARY);
endmodule : dic_input_cond_props
bind dic_input_cond dic_input_cond_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .pin_in(pin_in), .bus_req(bus_req), .rdata(rdata),
  .thresh_24v(thresh_24v), .diff_mode(diff_mode), .summary(summary),
  .motion_permit(motion_permit), .ilock_error(ilock_error), .ilock_event(ilock_event)
);
`default_nettype wire

// ==== bench/dic_input_cond_test.sv ====
`default_nettype none
module dic_input_cond_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;
  localparam int MS = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] want = 16'h0;
  logic [15:0] pin_in, thr;
  dic_bus_type bus_req = '0;
  logic [31:0] rdata, summary;
  logic dif, permit, err, evt;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  dic_switches u_sw (.clk(clk), .want(want), .pin_in(pin_in));
  dic_input_cond #(.MS_CYCLES(MS)) dut (.clk(clk), .rst_n(rst_n), .pin_in(pin_in),
    .bus_req(bus_req), .rdata(rdata), .thresh_24v(thr), .diff_mode(dif),
    .summary(summary), .motion_permit(permit), .ilock_error(err), .ilock_event(evt));
  // ====
  // clock, watchdog, helpers
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk(n, e, rdata);
    @(posedge clk);
  endtask : rd
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  function automatic logic [31:0] norm(logic [15:0] p, g, v, os, ol);
    logic [15:0] l;
    l = ((os & ol) | (~os & p)) ^ v;
    return {l, 12'h0, l[3:0] & g[3:0]};
  endfunction : norm
  // ====
  // scenarios
  task automatic t_regs;
    wr(A_THRESH, 32'h0000_A5A5);
    rd(A_THRESH, 32'h0000_A5A5, "thresh");
    chk("thr pins", 32'h0000_A5A5, {16'h0, thr});
    wr(A_RAW, 32'hFFFF_FFFF);
    rd(A_RAW, 32'h0, "raw ro");
    wr(A_SUMMARY, 32'hFFFF_FFFF);
    rd(A_SUMMARY, 32'h0, "sum ro");
    rd(8'hFC, 32'h0, "unmapped");
  endtask : t_regs
  task automatic t_norm;
    want <= 16'h00C5;
    settle(3 * MS);
    rd(A_RAW, 32'hC5, "raw");
    chk("levels", norm(16'hC5, 0, 0, 0, 0), summary);
    wr(A_GATE, 32'h7);
    wr(A_POL, 32'h3);
    wr(A_OVR_SEL, 32'h0104);
    wr(A_OVR_LVL, 32'h0100);
    settle(1);
    chk("mixed", norm(16'hC5, 7, 3, 16'h0104, 16'h0100), summary);
    want <= 16'h00C4;
    repeat (MS / 2) @(posedge clk);
    want <= 16'h00C5;
    // input 1 is high and inverted, so its level must stay 0 throughout
    for (int i = 0; i < 3 * MS; i++) begin
      settle(1);
      chk("glitch lvl", 32'h0, {31'h0, summary[16]});
    end
    rd(A_RAW, 32'hC5, "glitch");
  endtask : t_norm
  task automatic t_diff;
    wr(A_DIFF, 32'h1);
    chk("diff", 32'h1, {31'h0, dif});
    want <= 16'h0012;
    settle(3 * MS);
    rd(A_RAW, 32'h1, "pairs");
    wr(A_DIFF, 32'h0);
    want <= 16'h00C5;
    settle(3 * MS);
  endtask : t_diff
  task automatic t_route;
    logic [7:0] cs[6] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h10, 8'h90};
    logic ex[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    wr(A_ROUTE, 32'h1);
    settle(1);
    chk("preload", norm(16'hC5, 7, 3, 16'h0104, 16'h0100), summary);
    wr(A_POL, 32'hFFFF);
    settle(1);
    chk("frozen", norm(16'hC5, 7, 3, 16'h0104, 16'h0100), summary);
    for (int i = 0; i < 6; i++) begin
      wr(8'h80, {24'hFFFFFF, cs[i]});
      settle(1);
      chk("routed", {31'h0, ex[i]}, {31'h0, summary[16]});
    end
    rd(8'h80, 32'h90, "map");
  endtask : t_route
  task automatic t_ilock;
    wr(8'h4C, 32'h80);
    wr(A_GATE, 32'h8);
    settle(1);
    chk("permit", 32'h1, {31'h0, permit});
    wr(8'h4C, 32'h00);
    settle(1);
    chk("error", 32'h1, {31'h0, err});
    chk("event", 32'h1, {31'h0, evt});
    settle(1);
    chk("event end", 32'h0, {31'h0, evt});
    wr(8'h4C, 32'h84);
    settle(1);
    chk("release", 32'h1, {31'h0, permit});
  endtask : t_ilock
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_norm();
    t_diff();
    t_route();
    t_ilock();
    wrap_up();
  end
endmodule : dic_input_cond_test
`default_nettype wire
